// File: xotd_consts.vh
/*
 constants for the opcode timing decoder: register offsets, field positions,
 opcode values, flag positions, class codes and clock counts.
 assumes inclusion by bare name from the decoder sources and the bench.
*/
`ifndef XOTD_CONSTS_VH
`define XOTD_CONSTS_VH

// register byte offsets, one aligned 32-bit word each
`define XOTD_ADR_CTRL      8'h00
`define XOTD_ADR_INSN      8'h04
`define XOTD_ADR_DVD_LO    8'h08
`define XOTD_ADR_DVD_HI    8'h0c
`define XOTD_ADR_DIVISOR   8'h10
`define XOTD_ADR_STATUS    8'h14
`define XOTD_ADR_CYCLES    8'h18
`define XOTD_ADR_FLAGS     8'h1c

// control register fields
`define XOTD_CTRL_START    0
`define XOTD_CTRL_OP32     1
`define XOTD_CTRL_PMODE    2
`define XOTD_CTRL_RESET    3'h0

// status register fields
`define XOTD_ST_BUSY       0
`define XOTD_ST_DONE       1
`define XOTD_ST_DIVERR     2
`define XOTD_ST_UNSUP      3
`define XOTD_ST_MEMOP      4
`define XOTD_ST_CLS_LO     8

// flag vector positions, table column order
`define XOTD_FL_OF         8
`define XOTD_FL_DF         7
`define XOTD_FL_IF         6
`define XOTD_FL_TF         5
`define XOTD_FL_SF         4
`define XOTD_FL_ZF         3
`define XOTD_FL_AF         2
`define XOTD_FL_PF         1
`define XOTD_FL_CF         0
`define XOTD_MASK_NONE     9'h000
`define XOTD_MASK_OSZAPC   9'h11f
`define XOTD_MASK_SZAPC    9'h01f
`define XOTD_MASK_OSZAP    9'h11e
`define XOTD_MASK_DIV_WR   9'h018
`define XOTD_MASK_DIV_UND  9'h006

// opcode bytes
`define XOTD_OP_ESC        8'h0f
`define XOTD_OP2_MOVO      8'h40
`define XOTD_OP2_MOVNO     8'h41
`define XOTD_OP2_MOVS      8'h48
`define XOTD_OP2_MOVNS     8'h49
`define XOTD_OP2_MOVPE     8'h4a
`define XOTD_OP2_MOVPO     8'h4b
`define XOTD_OP2_CMPX_HI   7'h58
`define XOTD_OP_SEXT_DBL   8'h99
`define XOTD_OP_SEXT_IN    8'h98
`define XOTD_OP_ADJ_ADD    8'h27
`define XOTD_OP_ADJ_SUB    8'h2f
`define XOTD_OP_GRP_DEC_HI 7'h7f
`define XOTD_OP_DEC_SHORT  5'h09
`define XOTD_OP_GRP_DIV_HI 7'h7b
`define XOTD_OP_ENTER      8'hc8
`define XOTD_REG_DEC       3'h1
`define XOTD_REG_DIV       3'h6
`define XOTD_MOD_REG       2'h3

// instruction classes
`define XOTD_CLS_NONE      4'h0
`define XOTD_CLS_CMOV      4'h1
`define XOTD_CLS_CMPX      4'h2
`define XOTD_CLS_SEXT      4'h3
`define XOTD_CLS_ADJ       4'h4
`define XOTD_CLS_DEC       4'h5
`define XOTD_CLS_DIV       4'h6
`define XOTD_CLS_ENTER     4'h7

// clock counts with register operand or cache hit
`define XOTD_CYC_CMOV      10'h001
`define XOTD_CYC_CMPX      10'h00b
`define XOTD_CYC_SEXT      10'h002
`define XOTD_CYC_ADJ       10'h009
`define XOTD_CYC_DEC       10'h001
`define XOTD_CYC_DIV_BASE  10'h00d
`define XOTD_DIV_XTRA_B    10'h004
`define XOTD_DIV_XTRA_W    10'h00c
`define XOTD_DIV_XTRA_D    10'h01c
`define XOTD_CYC_ENT_BASE  10'h00a
`define XOTD_CYC_ENT_STEP  10'h003

`endif

// File: xotd_decode.v
/*
 combinational opcode decoder: class, base clock count, flag write and
 undefined masks, memory operand detect.
 assumes opcode bytes are stable while they are read.
*/
`timescale 1ns/1ps
`include "xotd_consts.vh"

module xotd_decode (
   input  wire [7:0] op0,
   input  wire [7:0] op1,
   input  wire [7:0] modrm,
   output reg  [3:0] cls,
   output reg  [9:0] base_cycles,
   output reg  [8:0] wr_mask,
   output reg  [8:0] und_mask,
   output reg        mem_op,
   output reg        wide
);
   wire [1:0] mod_f = modrm[7:6];
   wire [2:0] reg_f = modrm[5:3];

   always @* begin
      cls         = `XOTD_CLS_NONE;
      base_cycles = 10'h000;
      wr_mask     = `XOTD_MASK_NONE;
      und_mask    = `XOTD_MASK_NONE;
      mem_op      = 1'b0;
      wide        = 1'b0;
      if (op0 == `XOTD_OP_ESC) begin
         if (op1 == `XOTD_OP2_MOVO || op1 == `XOTD_OP2_MOVNO || op1 == `XOTD_OP2_MOVPE ||
             op1 == `XOTD_OP2_MOVPO || op1 == `XOTD_OP2_MOVNS || op1 == `XOTD_OP2_MOVS) begin
            cls         = `XOTD_CLS_CMOV;
            base_cycles = `XOTD_CYC_CMOV;
            mem_op      = (mod_f != `XOTD_MOD_REG);
         end else if (op1[7:1] == `XOTD_OP2_CMPX_HI) begin
            cls         = `XOTD_CLS_CMPX;
            base_cycles = `XOTD_CYC_CMPX;
            wr_mask     = `XOTD_MASK_OSZAPC;
            mem_op      = (mod_f != `XOTD_MOD_REG);
            wide        = op1[0];
         end
      end else if (op0 == `XOTD_OP_SEXT_DBL || op0 == `XOTD_OP_SEXT_IN) begin
         cls         = `XOTD_CLS_SEXT;
         base_cycles = `XOTD_CYC_SEXT;
      end else if (op0 == `XOTD_OP_ADJ_ADD || op0 == `XOTD_OP_ADJ_SUB) begin
         cls         = `XOTD_CLS_ADJ;
         base_cycles = `XOTD_CYC_ADJ;
         wr_mask     = `XOTD_MASK_SZAPC;
      end else if ((op0[7:1] == `XOTD_OP_GRP_DEC_HI && reg_f == `XOTD_REG_DEC) ||
                   op0[7:3] == `XOTD_OP_DEC_SHORT) begin
         cls         = `XOTD_CLS_DEC;
         base_cycles = `XOTD_CYC_DEC;
         wr_mask     = `XOTD_MASK_OSZAP;
         mem_op      = (op0[7:3] != `XOTD_OP_DEC_SHORT) && (mod_f != `XOTD_MOD_REG);
      end else if (op0[7:1] == `XOTD_OP_GRP_DIV_HI && reg_f == `XOTD_REG_DIV) begin
         cls         = `XOTD_CLS_DIV;
         base_cycles = `XOTD_CYC_DIV_BASE;
         wr_mask     = `XOTD_MASK_DIV_WR;
         und_mask    = `XOTD_MASK_DIV_UND;
         mem_op      = (mod_f != `XOTD_MOD_REG);
         wide        = op0[0];
      end else if (op0 == `XOTD_OP_ENTER) begin
         cls         = `XOTD_CLS_ENTER;
         base_cycles = `XOTD_CYC_ENT_BASE;
         mem_op      = 1'b1;
      end
   end
endmodule

// File: xotd_timer.v
/*
 execution timer: counts down the clock count of one instruction, stalls
 while a memory operand waits, reports the elapsed cycles.
 assumes start is a one-cycle pulse given only while idle.
*/
`timescale 1ns/1ps

module xotd_timer #(
   parameter CW = 10,
   parameter EW = 16
) (
   input  wire          mclk,
   input  wire          rst,
   input  wire          start,
   input  wire [CW-1:0] load_cycles,
   input  wire          mem_op,
   input  wire          mem_wait,
   output reg           busy,
   output reg           done,
   output reg  [EW-1:0] elapsed
);
   reg  [CW-1:0] remain;
   reg           hold_mem;
   wire          stall = hold_mem & mem_wait;

   always @(posedge mclk) begin
      if (rst) begin
         busy     <= 1'b0;
         done     <= 1'b0;
         elapsed  <= {EW{1'b0}};
         remain   <= {CW{1'b0}};
         hold_mem <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start && !busy) begin
            busy     <= 1'b1;
            remain   <= load_cycles;
            hold_mem <= mem_op;
            elapsed  <= {EW{1'b0}};
         end else if (busy) begin
            elapsed <= elapsed + {{(EW-1){1'b0}}, 1'b1};
            if (!stall) begin
               remain <= remain - {{(CW-1){1'b0}}, 1'b1};
               // last counted cycle, extra wait cycles already absorbed
               if (remain == {{(CW-1){1'b0}}, 1'b1}) begin
                  busy <= 1'b0;
                  done <= 1'b1;
               end
            end
         end
      end
   end
endmodule

// File: xotd_core.v
/*
 opcode timing decoder top: classic wishbone register slave, decode of one
 instruction, divide timing and fault check, stack-frame timing, timer.
 assumes a single-cycle classic wishbone master on mclk and a mem_wait
 level from the memory side that is high while an operand access waits.
*/
`timescale 1ns/1ps
`include "xotd_consts.vh"

// Behaviour
// - overflow move: one clock, flags kept
// - no-overflow move: one clock, flags kept
// - parity-even move: one clock, flags kept
// - parity-odd move: one clock, flags kept
// - not-negative move: one clock, flags kept
// - register compare-exchange: eleven clocks, six flags
// - memory compare-exchange: eleven clocks, six flags
// - sign extend into data register: two clocks
// - sign extend in place: two clocks
// - add adjust: nine clocks, five flags
// - subtract adjust: nine clocks, five flags
// - decrement: one clock, carry kept
// - divide: size-dependent thirteen-to-forty-one clocks
// - frame entry: ten plus three per level
module xotd_core #(
   parameter CW = 10,
   parameter EW = 16
) (
   input  wire        mclk,
   input  wire        rst,
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [7:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   input  wire        mem_wait,
   output wire        busy,
   output wire        insn_done,
   output reg         divide_error
);
   localparam ST_IDLE = 3'b001;
   localparam ST_RUN  = 3'b010;
   localparam ST_FIN  = 3'b100;

   reg  [2:0]    state;
   reg  [2:0]    next_state;
   reg           op32;
   reg           pmode;
   reg  [31:0]   insn;
   reg  [31:0]   dvd_lo;
   reg  [31:0]   dvd_hi;
   reg  [31:0]   divisor;
   reg           done_flag;
   reg           err_flag;
   reg           unsup_flag;
   reg  [3:0]    last_cls;
   reg           last_mem;
   reg  [8:0]    last_wr;
   reg  [8:0]    last_und;
   reg  [EW-1:0] last_cycles;
   reg           launch;
   reg  [CW-1:0] launch_cycles;
   reg           launch_mem;

   wire [3:0]    dec_cls;
   wire [9:0]    dec_base;
   wire [8:0]    dec_wr;
   wire [8:0]    dec_und;
   wire          dec_mem;
   wire          dec_wide;
   wire          tmr_busy;
   wire          tmr_done;
   wire [EW-1:0] tmr_elapsed;

   wire          bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire          bus_wr   = bus_req & wb_we_i;
   wire          start_wr = bus_wr && wb_adr_i == `XOTD_ADR_CTRL && wb_sel_i[0] &&
                            wb_dat_i[`XOTD_CTRL_START];
   wire          go       = start_wr && state == ST_IDLE;

   xotd_decode u_dec (
      .op0         (insn[7:0]),
      .op1         (insn[15:8]),
      .modrm       (insn[23:16]),
      .cls         (dec_cls),
      .base_cycles (dec_base),
      .wr_mask     (dec_wr),
      .und_mask    (dec_und),
      .mem_op      (dec_mem),
      .wide        (dec_wide)
   );

   xotd_timer #(
      .CW (CW),
      .EW (EW)
   ) u_tmr (
      .mclk        (mclk),
      .rst         (rst),
      .start       (launch),
      .load_cycles (launch_cycles),
      .mem_op      (launch_mem),
      .mem_wait    (mem_wait),
      .busy        (tmr_busy),
      .done        (tmr_done),
      .elapsed     (tmr_elapsed)
   );

   // operand size of the divide: byte, word or doubleword
   wire          div_byte = ~dec_wide;
   wire          div_dw   = dec_wide & op32;

   // dividend is twice the divisor width, high half overflows the quotient
   wire [31:0]   dvs_eff  = div_byte ? {24'h000000, divisor[7:0]} :
                            div_dw   ? divisor : {16'h0000, divisor[15:0]};
   wire [31:0]   dvd_top  = div_byte ? {24'h000000, dvd_lo[15:8]} :
                            div_dw   ? dvd_hi : {16'h0000, dvd_hi[15:0]};
   wire [63:0]   dvd_all  = div_byte ? {48'h0, dvd_lo[15:0]} :
                            div_dw   ? {dvd_hi, dvd_lo} : {32'h0, dvd_hi[15:0], dvd_lo[15:0]};
   wire          div_zero = (dvs_eff == 32'h00000000);
   wire          div_ovf  = (dvd_top >= dvs_eff);
   wire          div_bad  = div_zero | div_ovf;

   function [6:0] bit_len;
      input [63:0] v;
      integer i;
      begin
         bit_len = 7'h00;
         for (i = 0; i < 64; i = i + 1) begin
            if (v[i])
               bit_len = i[6:0] + 7'h01;
         end
      end
   endfunction

   // quotient length estimate drives the extra clocks, capped per size
   wire [6:0]    q_len_raw = bit_len(dvd_all) - bit_len({32'h0, dvs_eff}) + 7'h01;
   wire [9:0]    div_cap   = div_byte ? `XOTD_DIV_XTRA_B :
                             div_dw   ? `XOTD_DIV_XTRA_D : `XOTD_DIV_XTRA_W;
   wire [9:0]    q_len     = (bit_len(dvd_all) < bit_len({32'h0, dvs_eff})) ? 10'h000 :
                             {3'b000, q_len_raw};
   wire [9:0]    div_xtra  = (q_len > div_cap) ? div_cap : q_len;
   wire [9:0]    div_cyc   = dec_base + div_xtra;

   // level 1 gives 13 and level 0 gives 10 from the same sum
   wire [9:0]    ent_lvl   = {2'b00, insn[31:24]};
   wire [9:0]    ent_mul   = ent_lvl * `XOTD_CYC_ENT_STEP;
   wire [9:0]    ent_cyc   = dec_base + ent_mul;

   wire [9:0]    run_cyc   = (dec_cls == `XOTD_CLS_DIV)   ? div_cyc :
                             (dec_cls == `XOTD_CLS_ENTER) ? ent_cyc : dec_base;
   wire          fault     = (dec_cls == `XOTD_CLS_DIV) && div_bad;
   wire          unknown   = (dec_cls == `XOTD_CLS_NONE);

   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (go && !fault && !unknown)
               next_state = ST_RUN;
         end
         ST_RUN: begin
            if (tmr_done)
               next_state = ST_FIN;
         end
         ST_FIN: begin
            next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always @(posedge mclk) begin
      if (rst) begin
         state         <= ST_IDLE;
         launch        <= 1'b0;
         launch_cycles <= {CW{1'b0}};
         launch_mem    <= 1'b0;
         done_flag     <= 1'b0;
         err_flag      <= 1'b0;
         unsup_flag    <= 1'b0;
         divide_error  <= 1'b0;
         last_cls      <= `XOTD_CLS_NONE;
         last_mem      <= 1'b0;
         last_wr       <= `XOTD_MASK_NONE;
         last_und      <= `XOTD_MASK_NONE;
         last_cycles   <= {EW{1'b0}};
      end else begin
         state        <= next_state;
         launch       <= 1'b0;
         divide_error <= 1'b0;
         if (go) begin
            last_cls   <= dec_cls;
            last_mem   <= dec_mem;
            last_wr    <= fault ? `XOTD_MASK_NONE : dec_wr;
            last_und   <= fault ? `XOTD_MASK_NONE : dec_und;
            err_flag   <= fault;
            unsup_flag <= unknown;
            // a fault or an unknown opcode finishes at once with no count
            done_flag  <= fault | unknown;
            divide_error <= fault;
            if (fault || unknown)
               last_cycles <= {EW{1'b0}};
            if (!fault && !unknown) begin
               launch        <= 1'b1;
               launch_cycles <= run_cyc[CW-1:0];
               launch_mem    <= dec_mem;
            end
         end
         if (tmr_done) begin
            done_flag   <= 1'b1;
            // elapsed already counts the edge that raised done
            last_cycles <= tmr_elapsed;
         end
      end
   end

   assign busy      = (state != ST_IDLE) | launch | tmr_busy;
   assign insn_done = tmr_done | divide_error;

   always @(posedge mclk) begin
      if (rst) begin
         op32    <= 1'b0;
         pmode   <= 1'b0;
         insn    <= 32'h00000000;
         dvd_lo  <= 32'h00000000;
         dvd_hi  <= 32'h00000000;
         divisor <= 32'h00000000;
      end else if (bus_wr && !busy) begin
         // operands are frozen while an instruction runs
         case (wb_adr_i)
            `XOTD_ADR_CTRL: begin
               if (wb_sel_i[0]) begin
                  op32  <= wb_dat_i[`XOTD_CTRL_OP32];
                  pmode <= wb_dat_i[`XOTD_CTRL_PMODE];
               end
            end
            `XOTD_ADR_INSN: begin
               insn <= merge(insn, wb_dat_i, wb_sel_i);
            end
            `XOTD_ADR_DVD_LO: begin
               dvd_lo <= merge(dvd_lo, wb_dat_i, wb_sel_i);
            end
            `XOTD_ADR_DVD_HI: begin
               dvd_hi <= merge(dvd_hi, wb_dat_i, wb_sel_i);
            end
            `XOTD_ADR_DIVISOR: begin
               divisor <= merge(divisor, wb_dat_i, wb_sel_i);
            end
            default: begin
               op32 <= op32;
            end
         endcase
      end
   end

   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0]  sel;
      integer b;
      begin
         merge = old;
         for (b = 0; b < 4; b = b + 1) begin
            if (sel[b])
               merge[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
   endfunction

   always @(posedge mclk) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= bus_req;
         if (bus_req && !wb_we_i) begin
            case (wb_adr_i)
               `XOTD_ADR_CTRL:    wb_dat_o <= {29'h0, pmode, op32, 1'b0};
               `XOTD_ADR_INSN:    wb_dat_o <= insn;
               `XOTD_ADR_DVD_LO:  wb_dat_o <= dvd_lo;
               `XOTD_ADR_DVD_HI:  wb_dat_o <= dvd_hi;
               `XOTD_ADR_DIVISOR: wb_dat_o <= divisor;
               `XOTD_ADR_STATUS:  wb_dat_o <= {20'h0, last_cls, 3'h0, last_mem, unsup_flag,
                                               err_flag, done_flag, busy};
               `XOTD_ADR_CYCLES:  wb_dat_o <= {{(32-EW){1'b0}}, last_cycles};
               `XOTD_ADR_FLAGS:   wb_dat_o <= {7'h0, last_und, 7'h0, last_wr};
               default:           wb_dat_o <= 32'h00000000;
            endcase
         end
      end
   end
endmodule

// File: xotd_properties.sv
/*
 concurrent checks for the opcode timing decoder top: bus handshake, pulses.
 assumes a bind onto xotd_core, one clock mclk and synchronous reset rst.
*/
`timescale 1ns/1ps
module xotd_checker #(
   parameter CW = 10,
   parameter EW = 16
) (
   input wire        mclk,
   input wire        rst,
   input wire        wb_cyc_i,
   input wire        wb_stb_i,
   input wire        wb_we_i,
   input wire [31:0] wb_dat_o,
   input wire        wb_ack_o,
   input wire        busy,
   input wire        insn_done,
   input wire        divide_error
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   reg [10:0] run_len;
   // longest legal run is a level-255 frame entry plus a few stalls
   always @(posedge mclk) begin
      if (rst || !busy)
         run_len <= 11'h000;
      else
         run_len <= run_len + 11'h001;
   end
   sequence s_take;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_answer;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   a_ack_answer: assert property (s_take |=> s_answer)
      else $error("ack missing or longer than one cycle");
   a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   a_rdata_hold: assert property (!(wb_cyc_i && wb_stb_i && !wb_we_i) |=> $stable(wb_dat_o))
      else $error("read data changed without read");
   a_done_pulse: assert property (insn_done |=> !insn_done)
      else $error("done longer than one cycle");
   a_fault_pulse: assert property (divide_error |=> !divide_error)
      else $error("divide fault longer than one cycle");
   a_run_min: assert property ($rose(busy) |=> busy)
      else $error("run shorter than two cycles");
   a_run_bound: assert property (run_len <= 11'h3e8)
      else $error("run too long");
   a_done_cause: assert property (insn_done |-> $past(busy) || divide_error)
      else $error("done without a run");
endmodule

// File: tb.sv
/*
 self-checking bench for the opcode timing decoder: wishbone register access,
 one task per instruction class (t_simple holds sign extend, adjust and decrement), clock counts read from the cycles register.
 assumes xotd_core and xotd_checker compiled before it.
*/
`timescale 1ns/1ps
`include "xotd_consts.vh"
module tb;
   reg         mclk;
   reg         rst;
   reg         wb_cyc_i;
   reg         wb_stb_i;
   reg         wb_we_i;
   reg  [7:0]  wb_adr_i;
   reg  [31:0] wb_dat_i;
   reg         mem_wait;
   wire [31:0] wb_dat_o;
   wire        wb_ack_o;
   wire        busy;
   wire        insn_done;
   wire        divide_error;
   integer     n_mismatch;
   integer     comparisons;
   integer     n_done = 0;
   integer     n_err = 0;
   reg  [31:0] rd;
   reg  [31:0] st;
   reg  [31:0] cy;
   reg  [31:0] fl;

   xotd_core dut (.mclk(mclk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mem_wait(mem_wait), .busy(busy),
      .insn_done(insn_done), .divide_error(divide_error));

   always #5 mclk = ~mclk;

   // pulses are counted here so a one-cycle pulse is never missed by a task
   always @(posedge mclk) begin
      if (insn_done === 1'b1) n_done <= n_done + 1;
      if (divide_error === 1'b1) n_err <= n_err + 1;
   end

   task complete_run;
      begin
         if (n_mismatch == 0 && comparisons > 0) begin
            $display("*** PASS ***");
         end else begin
            $display("*** FAIL ***");
         end
         $finish;
      end
   endtask

   task timed_out;
      begin
         n_mismatch = n_mismatch + 1;
         $display("[ERR] wait exp done got timeout");
         complete_run;
      end
   endtask

   task chk_reg(input [8*8:1] nm, input [31:0] e, input [31:0] g);
      begin
         comparisons = comparisons + 1;
         if (g !== e) begin
            n_mismatch = n_mismatch + 1;
            $display("[ERR] %0s exp %h got %h", nm, e, g);
         end
      end
   endtask

   task chk_bit(input [8*8:1] nm, input e, input g);
      begin
         comparisons = comparisons + 1;
         if (g !== e) begin
            n_mismatch = n_mismatch + 1;
            $display("[ERR] %0s exp %b got %b", nm, e, g);
         end
      end
   endtask

   task wb_xfer(input w, input [7:0] a, input [31:0] d);
      integer n;
      begin
         wb_cyc_i <= 1'b1;
         wb_stb_i <= 1'b1;
         wb_we_i  <= w;
         wb_adr_i <= a;
         wb_dat_i <= d;
         n = 0;
         do begin
            @(posedge mclk);
            n = n + 1;
         end while (wb_ack_o !== 1'b1 && n < 40);
         if (n >= 40) timed_out;
         rd = wb_dat_o;
         wb_cyc_i <= 1'b0;
         wb_stb_i <= 1'b0;
         wb_we_i  <= 1'b0;
         @(posedge mclk);
      end
   endtask

   // stall cycles start once the timer runs, so each one is counted for a memory operand instruction
   // size bit is set before start: the launch decodes with the stored size
   task run(input [31:0] code, input [31:0] ctrl, input integer stall);
      integer n;
      integer d0;
      begin
         wb_xfer(1'b1, `XOTD_ADR_CTRL, ctrl & 32'hfffffffe);
         wb_xfer(1'b1, `XOTD_ADR_INSN, code);
         d0 = n_done;
         wb_xfer(1'b1, `XOTD_ADR_CTRL, ctrl);
         if (stall > 0) begin
            mem_wait <= 1'b1;
            repeat (stall) @(posedge mclk);
            mem_wait <= 1'b0;
         end
         n = 0;
         while (n_done == d0 && n < 2000) begin
            @(posedge mclk);
            n = n + 1;
         end
         if (n >= 2000) timed_out;
         wb_xfer(1'b0, `XOTD_ADR_STATUS, 32'h0);
         st = rd;
         wb_xfer(1'b0, `XOTD_ADR_CYCLES, 32'h0);
         cy = rd;
         wb_xfer(1'b0, `XOTD_ADR_FLAGS, 32'h0);
         fl = rd;
      end
   endtask

   // status read lands after the state machine is back in idle
   task insn(input [31:0] op, input [31:0] ctrl, input integer stall, input [3:0] cls,
      input [31:0] n, input [8:0] wr, input [8:0] und, input mem);
      begin
         run(op, ctrl, stall);
         chk_reg("status", {20'h0, cls, 3'h0, mem, 4'h2}, st);
         chk_reg("cycles", n, cy);
         chk_reg("flags", {7'h0, und, 7'h0, wr}, fl);
      end
   endtask

   task t_cmov;
      begin
         insn(32'h00c0400f, 32'h1, 0, 4'h1, 1, 9'h000, 9'h000, 1'b0);
         insn(32'h00c0400f, 32'h5, 0, 4'h1, 1, 9'h000, 9'h000, 1'b0);
         insn(32'h00c1410f, 32'h5, 0, 4'h1, 1, 9'h000, 9'h000, 1'b0);
         insn(32'h00c24a0f, 32'h1, 0, 4'h1, 1, 9'h000, 9'h000, 1'b0);
         insn(32'h00c34b0f, 32'h1, 0, 4'h1, 1, 9'h000, 9'h000, 1'b0);
         insn(32'h0006490f, 32'h1, 0, 4'h1, 1, 9'h000, 9'h000, 1'b1);
      end
   endtask

   task t_cmpx;
      begin
         insn(32'h00c1b00f, 32'h1, 0, 4'h2, 11, 9'h11f, 9'h000, 1'b0);
         insn(32'h0001b10f, 32'h3, 3, 4'h2, 14, 9'h11f, 9'h000, 1'b1);
      end
   endtask

   task t_simple;
      begin
         insn(32'h00000099, 32'h1, 0, 4'h3, 2, 9'h000, 9'h000, 1'b0);
         insn(32'h00000098, 32'h1, 0, 4'h3, 2, 9'h000, 9'h000, 1'b0);
         insn(32'h00000027, 32'h1, 0, 4'h4, 9, 9'h01f, 9'h000, 1'b0);
         insn(32'h0000002f, 32'h1, 0, 4'h4, 9, 9'h01f, 9'h000, 1'b0);
         insn(32'h00000027, 32'h1, 3, 4'h4, 9, 9'h01f, 9'h000, 1'b0);
         insn(32'h00c800fe, 32'h1, 0, 4'h5, 1, 9'h11e, 9'h000, 1'b0);
         insn(32'h00c900ff, 32'h1, 0, 4'h5, 1, 9'h11e, 9'h000, 1'b0);
         insn(32'h00000048, 32'h1, 0, 4'h5, 1, 9'h11e, 9'h000, 1'b0);
         insn(32'h0000004f, 32'h1, 0, 4'h5, 1, 9'h11e, 9'h000, 1'b0);
      end
   endtask

   task div_regs(input [31:0] lo, input [31:0] hi, input [31:0] dv);
      begin
         wb_xfer(1'b1, `XOTD_ADR_DVD_LO, lo);
         wb_xfer(1'b1, `XOTD_ADR_DVD_HI, hi);
         wb_xfer(1'b1, `XOTD_ADR_DIVISOR, dv);
      end
   endtask

   task t_div;
      begin
         div_regs(32'h64, 32'h0, 32'h3);
         insn(32'h00f000f6, 32'h1, 0, 4'h6, 17, 9'h018, 9'h006, 1'b0);
         div_regs(32'h10, 32'h0, 32'h10);
         insn(32'h00f000f7, 32'h1, 0, 4'h6, 14, 9'h018, 9'h006, 1'b0);
         div_regs(32'hffffffff, 32'h0, 32'h1);
         insn(32'h00f000f7, 32'h3, 0, 4'h6, 41, 9'h018, 9'h006, 1'b0);
      end
   endtask

   task t_fault(input [31:0] lo, input [31:0] dv);
      integer e0;
      begin
         div_regs(lo, 32'h0, dv);
         e0 = n_err;
         run(32'h00f000f6, 32'h1, 0);
         chk_bit("fault", 1'b1, n_err == e0 + 1);
         chk_bit("err_bit", 1'b1, st[2]);
         chk_reg("cycles", 32'h0, cy);
         chk_reg("flags", 32'h0, fl);
      end
   endtask

   task t_enter;
      begin
         insn(32'h000000c8, 32'h1, 0, 4'h7, 10, 9'h000, 9'h000, 1'b1);
         insn(32'h010000c8, 32'h1, 0, 4'h7, 13, 9'h000, 9'h000, 1'b1);
         insn(32'h020000c8, 32'h1, 3, 4'h7, 19, 9'h000, 9'h000, 1'b1);
         insn(32'hff0000c8, 32'h1, 0, 4'h7, 775, 9'h000, 9'h000, 1'b1);
      end
   endtask

   // unknown opcode finishes at once with no done pulse, so no wait here
   task t_unknown;
      begin
         wb_xfer(1'b1, `XOTD_ADR_INSN, 32'h00000090);
         wb_xfer(1'b1, `XOTD_ADR_CTRL, 32'h1);
         wb_xfer(1'b0, `XOTD_ADR_STATUS, 32'h0);
         chk_reg("unsup", 32'h0000000a, rd);
         wb_xfer(1'b0, `XOTD_ADR_CYCLES, 32'h0);
         chk_reg("cycles", 32'h0, rd);
      end
   endtask

   task t_unmapped;
      begin
         wb_xfer(1'b1, 8'h20, 32'h5a5a5a5a);
         wb_xfer(1'b0, 8'h20, 32'h0);
         chk_reg("unmapped", 32'h0, rd);
      end
   endtask

   initial begin
      mclk = 1'b0;
      rst = 1'b1;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 8'h00;
      wb_dat_i = 32'h0;
      mem_wait = 1'b0;
      n_mismatch = 0;
      comparisons = 0;
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      t_unmapped;
      t_cmov;
      t_cmpx;
      t_simple;
      t_div;
      t_fault(32'h64, 32'h0);
      t_fault(32'h0300, 32'h3);
      t_enter;
      t_unknown;
      complete_run;
   end
endmodule

bind xotd_core xotd_checker #(.CW(CW), .EW(EW)) u_chk (.mclk(mclk), .rst(rst),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .busy(busy), .insn_done(insn_done), .divide_error(divide_error));
